// [hw/video_decoder_proc_controls.sv]
// control and status registers for the decoder processing stages
`timescale 1ns/1ps
`default_nettype none

module video_decoder_proc_controls (
    input  wire logic                      mclk_in,        // pixel clock
    input  wire logic                      rst_n_in,       // async reset
    input  wire logic                      reg_wr_in,      // write strobe
    input  wire logic                      reg_rd_in,      // read strobe
    input  wire logic [7:0]                reg_idx_in,     // register index
    input  wire logic [7:0]                reg_wdata_in,   // write data
    output logic      [7:0]                reg_rdata_out,  // read data
    input  wire logic                      secam_det_in,   // detector secam
    input  wire logic                      fsc_det_in,     // detector 3.58
    input  wire logic                      test_gain_in,   // test gain mode
    input  wire logic [2:0]                auto_luma_in,   // standard luma set
    input  wire logic [2:0]                auto_chroma_in, // standard chroma
    input  wire logic                      vsync_in,       // vertical sync
    input  wire logic                      odd_field_in,   // odd field flag
    input  wire logic                      vact_in,        // raw vert active
    input  wire logic                      comb_en_in,     // internal comb en
    output proc_ctrl_pkg::proc_ctrl_t      ctrl_out,       // decoded controls
    output logic                           vact_out,       // gated vert active
    output logic                           comb_gate_out   // comb enable
);

    // -------------------------------------------------------------------
    // storage
    // -------------------------------------------------------------------
    logic [7:0]  lag_reg;          // chroma lag and phase compare
    logic [5:0]  subcarrier_decode_ctrl_status_reg;        // writable subcarrier_decode_ctrl_status bits
    logic [7:0]  gain_reg;         // colour gain
    logic [7:0]  tint_reg;         // tint angle
    logic [7:0]  vert_a_reg;       // vertical processing a
    logic [7:0]  vert_b_reg;       // vertical processing b
    logic [7:0]  vert_c_reg;       // vertical processing c
    logic [7:0]  hlow_reg;         // horizontal ratio low
    logic [7:0]  hhigh_reg;        // horizontal ratio high
    logic [7:0]  vlow_reg;         // vertical ratio low
    logic [7:0]  vhigh_reg;        // vertical ratio high

    logic [14:0] hratio_act_reg;   // horizontal ratio in use
    logic [13:0] vratio_act_reg;   // vertical ratio in use

    logic        vsync_d_reg;      // vsync delayed for edge
    logic [7:0]  rdata_next;       // read mux result
    proc_ctrl_pkg::proc_ctrl_t ctrl_next; // decoded controls

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    // write hit on one index
    function automatic logic wr_hit(input logic we, input logic [7:0] idx,
                                    input logic [7:0] want);
        wr_hit = we && (idx == want);
    endfunction : wr_hit

    // override code against detector level
    function automatic logic apply_ovr(input logic [1:0] code,
                                       input logic det);
        case (code)
            proc_ctrl_pkg::OVR_FORCE_NO:  apply_ovr = 1'b0;
            proc_ctrl_pkg::OVR_FORCE_YES: apply_ovr = 1'b1;
            // codes 0 and 1 follow the detector
            default:                      apply_ovr = det;
        endcase
    endfunction : apply_ovr

    // -------------------------------------------------------------------
    // field decode
    // -------------------------------------------------------------------
    wire [1:0] secam_ovr  = subcarrier_decode_ctrl_status_reg[proc_ctrl_pkg::POS_SECAM_OVR_LO +: 2];
    wire [1:0] fsc_ovr    = subcarrier_decode_ctrl_status_reg[proc_ctrl_pkg::POS_FSC_OVR_LO +: 2];
    wire [2:0] vfilt_code = vert_a_reg[proc_ctrl_pkg::POS_VFILT_LO +: 3];
    wire       luma_man   = vert_a_reg[proc_ctrl_pkg::POS_LUMA_MANUAL];
    wire [2:0] luma_man_c = vert_a_reg[proc_ctrl_pkg::POS_LUMA_COEF_LO +: 3];
    wire       chr_man    = vert_c_reg[proc_ctrl_pkg::POS_CHR_MANUAL];
    wire [2:0] chr_man_c  = vert_c_reg[proc_ctrl_pkg::POS_CHR_COEF_LO +: 3];
    wire [1:0] vscale     = vert_b_reg[proc_ctrl_pkg::POS_VSCALE_LO +: 2];
    wire [2:0] chr_coef   = chr_man ? chr_man_c : auto_chroma_in;

    // ratio shadows load on the first cycle of sync
    wire       vsync_rise = vsync_in && !vsync_d_reg;

    // enable bit of the field now in progress
    wire       field_en   = odd_field_in ?
                            vert_c_reg[proc_ctrl_pkg::POS_VACT_ODD] :
                            vert_c_reg[proc_ctrl_pkg::POS_VACT_EVEN];
    wire       vact_gated = vact_in && field_en;

    // comb gate source select
    wire       gate_mode  = hlow_reg[proc_ctrl_pkg::POS_GATE_MODE];
    wire       comb_next  = gate_mode ? vact_gated : comb_en_in;

    // scaler path for each filter code
    function automatic proc_ctrl_pkg::path_t scaler_of(input logic [2:0] c);
        case (c)
            3'h1:    scaler_of = proc_ctrl_pkg::PATH_FULL;
            3'h2:    scaler_of = proc_ctrl_pkg::PATH_OFF;
            3'h3:    scaler_of = proc_ctrl_pkg::PATH_LPF;
            3'h4:    scaler_of = proc_ctrl_pkg::PATH_OFF;
            // codes 5 to 7 act as code 0
            default: scaler_of = proc_ctrl_pkg::PATH_LPF;
        endcase
    endfunction : scaler_of

    // comb path for each filter code
    function automatic proc_ctrl_pkg::path_t comb_of(input logic [2:0] c);
        case (c)
            3'h1:    comb_of = proc_ctrl_pkg::PATH_OFF;
            3'h2:    comb_of = proc_ctrl_pkg::PATH_FULL;
            3'h3:    comb_of = proc_ctrl_pkg::PATH_OFF;
            3'h4:    comb_of = proc_ctrl_pkg::PATH_HPF;
            // codes 5 to 7 act as code 0
            default: comb_of = proc_ctrl_pkg::PATH_HPF;
        endcase
    endfunction : comb_of

    // -------------------------------------------------------------------
    // decoded control
    // -------------------------------------------------------------------
    always_comb begin
        ctrl_next.secam_assumed     = apply_ovr(secam_ovr, secam_det_in);

        ctrl_next.fsc_358           = apply_ovr(fsc_ovr, fsc_det_in);

        ctrl_next.track_field_only  =
            subcarrier_decode_ctrl_status_reg[proc_ctrl_pkg::POS_FOLLOW_MODE];

        ctrl_next.subcarrier_decode_ctrl_status_lpf_bypass  =
            subcarrier_decode_ctrl_status_reg[proc_ctrl_pkg::POS_SUBCARRIER_DECODE_CTRL_STATUS_BYPASS];

        ctrl_next.color_gain        = gain_reg;
        ctrl_next.gain_signed       = !test_gain_in;

        ctrl_next.tint              = tint_reg;

        ctrl_next.scaler_path       = scaler_of(vfilt_code);
        ctrl_next.comb_path         = comb_of(vfilt_code);

        ctrl_next.five_tap          =
            vert_a_reg[proc_ctrl_pkg::POS_TAP_SELECT];

        ctrl_next.luma_coef         = luma_man ? luma_man_c : auto_luma_in;
        ctrl_next.luma_coef_auto    = !luma_man;

        ctrl_next.vscale_on         = (vscale == proc_ctrl_pkg::VSCALE_ON);
        ctrl_next.line_delay        = (vscale == proc_ctrl_pkg::VSCALE_ON) ?
                                      2'h0 : vscale - 2'h1;

        ctrl_next.decim_on          =
            !vert_b_reg[proc_ctrl_pkg::POS_DECIM_DIS];
        ctrl_next.decim_wide        =
            vert_b_reg[proc_ctrl_pkg::POS_DECIM_WIDE];

        ctrl_next.hlpf_bw           =
            vert_b_reg[proc_ctrl_pkg::POS_HLPF_LO +: 3];

        ctrl_next.luma_vert_reduced =
            vert_c_reg[proc_ctrl_pkg::POS_VERT_BW];

        ctrl_next.acomb_on          =
            vert_c_reg[proc_ctrl_pkg::POS_ACOMB_EN];

        ctrl_next.acomb_coef75      =
            vlow_reg[proc_ctrl_pkg::POS_ACOMB_COEF];
        ctrl_next.acomb_thr_low     =
            vlow_reg[proc_ctrl_pkg::POS_ACOMB_THR];

        ctrl_next.chroma_coef       = chr_coef;
        ctrl_next.chroma_coef_auto  = !chr_man;
        ctrl_next.chroma_mute       =
            chr_man && (chr_man_c == proc_ctrl_pkg::CHR_COEF_OFF);

        ctrl_next.chroma_lag        = lag_reg[proc_ctrl_pkg::POS_LAG_LO +: 4];
        ctrl_next.horiz_ratio       = hratio_act_reg;
        ctrl_next.vert_ratio        = vratio_act_reg;
    end

    // -------------------------------------------------------------------
    // read mux
    // -------------------------------------------------------------------
    always_comb begin
        case (reg_idx_in)
            proc_ctrl_pkg::IDX_CHROMA_LAG:  rdata_next = lag_reg;
            proc_ctrl_pkg::IDX_SUBCARRIER_DECODE_CTRL_STATUS:       rdata_next = {fsc_det_in,
                                                          secam_det_in,
                                                          subcarrier_decode_ctrl_status_reg};
            proc_ctrl_pkg::IDX_COLOR_GAIN:  rdata_next = gain_reg;
            proc_ctrl_pkg::IDX_TINT:        rdata_next = tint_reg;
            proc_ctrl_pkg::IDX_VERT_A:      rdata_next = vert_a_reg;
            proc_ctrl_pkg::IDX_VERT_B:      rdata_next = vert_b_reg;
            proc_ctrl_pkg::IDX_VERT_C:      rdata_next = vert_c_reg;
            proc_ctrl_pkg::IDX_HRATIO_LOW:  rdata_next = hlow_reg;
            proc_ctrl_pkg::IDX_HRATIO_HIGH: rdata_next = hhigh_reg;
            proc_ctrl_pkg::IDX_VRATIO_LOW:  rdata_next = vlow_reg;
            proc_ctrl_pkg::IDX_VRATIO_HIGH: rdata_next = vhigh_reg;
            default:                        rdata_next = 8'h00;
        endcase
    end

    // -------------------------------------------------------------------
    // register writes
    // -------------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lag_reg    <= proc_ctrl_pkg::RST_ZERO;
            subcarrier_decode_ctrl_status_reg  <= 6'h00;
            gain_reg   <= proc_ctrl_pkg::RST_ZERO;
            tint_reg   <= proc_ctrl_pkg::RST_ZERO;
            vert_a_reg <= proc_ctrl_pkg::RST_ZERO;
            vert_b_reg <= proc_ctrl_pkg::RST_ZERO;
            vert_c_reg <= proc_ctrl_pkg::RST_VERT_C;
            hlow_reg   <= proc_ctrl_pkg::RST_ZERO;
            hhigh_reg  <= proc_ctrl_pkg::RST_ZERO;
            vlow_reg   <= proc_ctrl_pkg::RST_ZERO;
            vhigh_reg  <= proc_ctrl_pkg::RST_ZERO;
        end else begin
            if (wr_hit(reg_wr_in, reg_idx_in, proc_ctrl_pkg::IDX_CHROMA_LAG))
                lag_reg <= reg_wdata_in;

            // status bits are not writable
            if (wr_hit(reg_wr_in, reg_idx_in, proc_ctrl_pkg::IDX_SUBCARRIER_DECODE_CTRL_STATUS))
                subcarrier_decode_ctrl_status_reg <= reg_wdata_in[5:0];

            if (wr_hit(reg_wr_in, reg_idx_in, proc_ctrl_pkg::IDX_COLOR_GAIN))
                gain_reg <= reg_wdata_in;

            if (wr_hit(reg_wr_in, reg_idx_in, proc_ctrl_pkg::IDX_TINT))
                tint_reg <= reg_wdata_in;

            if (wr_hit(reg_wr_in, reg_idx_in, proc_ctrl_pkg::IDX_VERT_A))
                vert_a_reg <= reg_wdata_in;

            // bit 0 of this one is fixed at zero
            if (wr_hit(reg_wr_in, reg_idx_in, proc_ctrl_pkg::IDX_VERT_B))
                vert_b_reg <= {reg_wdata_in[7:1], 1'b0};

            if (wr_hit(reg_wr_in, reg_idx_in, proc_ctrl_pkg::IDX_VERT_C))
                vert_c_reg <= reg_wdata_in;

            if (wr_hit(reg_wr_in, reg_idx_in, proc_ctrl_pkg::IDX_HRATIO_LOW))
                hlow_reg <= reg_wdata_in;

            if (wr_hit(reg_wr_in, reg_idx_in, proc_ctrl_pkg::IDX_HRATIO_HIGH))
                hhigh_reg <= reg_wdata_in;

            if (wr_hit(reg_wr_in, reg_idx_in, proc_ctrl_pkg::IDX_VRATIO_LOW))
                vlow_reg <= reg_wdata_in;

            if (wr_hit(reg_wr_in, reg_idx_in, proc_ctrl_pkg::IDX_VRATIO_HIGH))
                vhigh_reg <= reg_wdata_in;
        end
    end

    // -------------------------------------------------------------------
    // ratio shadows, loaded on vsync rising edge
    // -------------------------------------------------------------------
    // both bytes land together, so a pair written between syncs never
    // reaches the scaler half old and half new
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            vsync_d_reg    <= 1'b0;
            hratio_act_reg <= 15'h0000;
            vratio_act_reg <= 14'h0000;
        end else begin
            vsync_d_reg <= vsync_in;

            if (vsync_rise) begin
                hratio_act_reg <= {hhigh_reg, hlow_reg[7:1]};
                vratio_act_reg <= {vhigh_reg, vlow_reg[7:2]};
            end
        end
    end

    // -------------------------------------------------------------------
    // output flops
    // -------------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_out      <= '0;
            vact_out      <= 1'b0;
            comb_gate_out <= 1'b0;
            reg_rdata_out <= 8'h00;
        end else begin
            // controls and gated strobes lag their cause by one
            ctrl_out      <= ctrl_next;
            vact_out      <= vact_gated;
            comb_gate_out <= comb_next;
            // read data held until the next read
            if (reg_rd_in)
                reg_rdata_out <= rdata_next;
        end
    end

endmodule : video_decoder_proc_controls

`default_nettype wire

// [shared/proc_ctrl_pkg.sv]
// constants and carrier types for the video processing control registers
package proc_ctrl_pkg;

    // -------------------------------------------------------------------
    // register indices
    // -------------------------------------------------------------------
    localparam logic [7:0] IDX_CHROMA_LAG   = 8'h13; // lag and phase compare
    localparam logic [7:0] IDX_SUBCARRIER_DECODE_CTRL_STATUS        = 8'h14; // subcarrier_decode_ctrl_status ctrl and status
    localparam logic [7:0] IDX_COLOR_GAIN   = 8'h15; // saturation
    localparam logic [7:0] IDX_TINT         = 8'h16; // hue
    localparam logic [7:0] IDX_VERT_A       = 8'h17; // luma vertical control
    localparam logic [7:0] IDX_VERT_B       = 8'h18; // scale mode, horiz luma
    localparam logic [7:0] IDX_VERT_C       = 8'h19; // chroma comb, vact gate
    localparam logic [7:0] IDX_HRATIO_LOW   = 8'h1a; // ratio low, gate mode
    localparam logic [7:0] IDX_HRATIO_HIGH  = 8'h1b; // horizontal ratio high
    localparam logic [7:0] IDX_VRATIO_LOW   = 8'h1c; // ratio low, comb bits
    localparam logic [7:0] IDX_VRATIO_HIGH  = 8'h1d; // vertical ratio high

    // -------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] RST_ZERO         = 8'h00; // most registers
    localparam logic [7:0] RST_VERT_C       = 8'h03; // both vact enables on

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int POS_LAG_LO        = 4; // chroma lag [7:4]
    localparam int POS_FSC_FOUND     = 7; // subcarrier found, read only
    localparam int POS_SECAM_FOUND   = 6; // secam found, read only
    localparam int POS_SUBCARRIER_DECODE_CTRL_STATUS_BYPASS  = 5; // subcarrier_decode_ctrl_status lowpass bypass
    localparam int POS_FOLLOW_MODE   = 4; // colour follow mode
    localparam int POS_FSC_OVR_LO    = 2; // subcarrier override [3:2]
    localparam int POS_SECAM_OVR_LO  = 0; // secam override [1:0]
    localparam int POS_LUMA_MANUAL   = 7; // luma comb manual
    localparam int POS_LUMA_COEF_LO  = 4; // luma comb coef [6:4]
    localparam int POS_TAP_SELECT    = 3; // vertical tap select
    localparam int POS_VFILT_LO      = 0; // luma vertical filter [2:0]
    localparam int POS_HLPF_LO       = 5; // horizontal lowpass [7:5]
    localparam int POS_DECIM_WIDE    = 4; // decimation wide
    localparam int POS_DECIM_DIS     = 3; // decimation disable
    localparam int POS_VSCALE_LO     = 1; // vertical scale mode [2:1]
    localparam int POS_CHR_MANUAL    = 7; // chroma comb manual
    localparam int POS_CHR_COEF_LO   = 4; // chroma comb coef [6:4]
    localparam int POS_ACOMB_EN      = 3; // adaptive comb enable
    localparam int POS_VERT_BW       = 2; // luma vertical bandwidth
    localparam int POS_VACT_EVEN     = 1; // vact enable even field
    localparam int POS_VACT_ODD      = 0; // vact enable odd field
    localparam int POS_GATE_MODE     = 0; // comb gate mode
    localparam int POS_ACOMB_COEF    = 1; // adaptive comb coef set
    localparam int POS_ACOMB_THR     = 0; // adaptive comb threshold

    // -------------------------------------------------------------------
    // codes
    // -------------------------------------------------------------------
    localparam logic [1:0] OVR_AUTO      = 2'h0; // follow the detector
    localparam logic [1:0] OVR_FORCE_NO  = 2'h2; // force not secam / 4.43
    localparam logic [1:0] OVR_FORCE_YES = 2'h3; // force secam / 3.58
    localparam logic [2:0] CHR_COEF_OFF  = 3'h7; // chroma comb output off
    localparam logic [1:0] VSCALE_ON     = 2'h0; // scaler active

    // filter path selections for scaler and comb
    typedef enum logic [1:0] {
        PATH_OFF  = 2'h0,
        PATH_LPF  = 2'h1,
        PATH_FULL = 2'h2,
        PATH_HPF  = 2'h3
    } path_t;

    // -------------------------------------------------------------------
    // decoded control handed to the datapaths
    // -------------------------------------------------------------------
    typedef struct packed {
        logic        secam_assumed;    // secam decoding in use
        logic        fsc_358;          // 3.58 mhz subcarrier in use
        logic        track_field_only; // tracking on field rate alone
        logic        subcarrier_decode_ctrl_status_lpf_bypass; // skip demodulator lowpass
        logic [7:0]  color_gain;       // saturation value
        logic        gain_signed;      // gain is two's complement
        logic [7:0]  tint;             // signed phase, 1.41 deg per lsb
        path_t       scaler_path;      // vertical scaler luma path
        path_t       comb_path;        // luma comb path
        logic        five_tap;         // 5-tap vertical scaler
        logic [2:0]  luma_coef;        // luma comb coefficient set
        logic        luma_coef_auto;   // luma set from the standard
        logic        vscale_on;        // vertical scaling active
        logic [1:0]  line_delay;       // lines of delay when off
        logic        decim_on;         // luma decimation active
        logic        decim_wide;       // decimation 1 mhz wider
        logic [2:0]  hlpf_bw;          // horizontal luma bandwidth code
        logic        luma_vert_reduced;// reduced vertical bandwidth
        logic        acomb_on;         // ntsc adaptive comb on
        logic        acomb_coef75;     // 75 percent comb set
        logic        acomb_thr_low;    // low threshold
        logic [2:0]  chroma_coef;      // chroma comb coefficient set
        logic        chroma_coef_auto; // chroma set from the standard
        logic        chroma_mute;      // chroma comb output off
        logic [3:0]  chroma_lag;       // chroma delay code
        logic [14:0] horiz_ratio;      // ratio over 2^15
        logic [13:0] vert_ratio;       // ratio over 2^14
    } proc_ctrl_t;

endpackage : proc_ctrl_pkg

// [tb/proc_ctrl_chk.sv]
// assertions on the processing control register ports
`timescale 1ns/1ps
`default_nettype none
module proc_ctrl_chk (
    input wire logic                      mclk_in,        // clock
    input wire logic                      rst_n_in,       // reset
    input wire logic                      reg_rd_in,      // read
    input wire logic [7:0]                reg_idx_in,     // index
    input wire logic [7:0]                reg_rdata_out,  // read data
    input wire logic                      secam_det_in,   // secam seen
    input wire logic                      fsc_det_in,     // 3.58 seen
    input wire logic [2:0]                auto_luma_in,   // luma set
    input wire logic [2:0]                auto_chroma_in, // chroma set
    input wire logic                      vsync_in,       // sync
    input wire logic                      vact_in,        // raw vact
    input wire proc_ctrl_pkg::proc_ctrl_t ctrl_out,       // controls
    input wire logic                      vact_out        // gated vact
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // read of the status register
    wire logic rd_st = reg_rd_in && reg_idx_in == proc_ctrl_pkg::IDX_SUBCARRIER_DECODE_CTRL_STATUS;
    property p_vact; vact_out |-> $past(vact_in); endproperty
    a_vact: assert property (p_vact)
        else $error("gated vact without raw vact");
    property p_sec;
        rd_st |=> reg_rdata_out[6] == $past(secam_det_in);
    endproperty
    a_sec: assert property (p_sec)
        else $error("secam status wrong");
    property p_fsc;
        rd_st |=> reg_rdata_out[7] == $past(fsc_det_in);
    endproperty
    a_fsc: assert property (p_fsc)
        else $error("subcarrier status wrong");
    property p_mute; ctrl_out.chroma_mute |-> !ctrl_out.chroma_coef_auto
        && ctrl_out.chroma_coef == proc_ctrl_pkg::CHR_COEF_OFF; endproperty
    a_mute: assert property (p_mute)
        else $error("chroma mute without code 7");
    property p_lau; ctrl_out.luma_coef_auto |->
        ctrl_out.luma_coef == $past(auto_luma_in); endproperty
    a_lau: assert property (p_lau)
        else $error("auto luma set wrong");
    property p_cau; ctrl_out.chroma_coef_auto |->
        ctrl_out.chroma_coef == $past(auto_chroma_in); endproperty
    a_cau: assert property (p_cau)
        else $error("auto chroma set wrong");
    property p_hr; $changed(ctrl_out.horiz_ratio) |-> $past(vsync_in)
        || $past(vsync_in, 2) || $past(vsync_in, 3); endproperty
    a_hr: assert property (p_hr)
        else $error("horizontal ratio moved without sync");
    property p_vr; $changed(ctrl_out.vert_ratio) |-> $past(vsync_in)
        || $past(vsync_in, 2) || $past(vsync_in, 3); endproperty
    a_vr: assert property (p_vr)
        else $error("vertical ratio moved without sync");
endmodule : proc_ctrl_chk
`default_nettype wire

// [tb/video_decoder_proc_controls_test.sv]
// self-checking bench for the processing control registers
`timescale 1ns/1ps
`default_nettype none
bind video_decoder_proc_controls proc_ctrl_chk u_chk (.mclk_in, .rst_n_in,
    .reg_rd_in, .reg_idx_in, .reg_rdata_out, .secam_det_in, .fsc_det_in,
    .auto_luma_in, .auto_chroma_in, .vsync_in, .vact_in, .ctrl_out,
    .vact_out);
module video_decoder_proc_controls_test;
    logic mclk_in = 1'h0, rst_n_in = 1'h0, reg_wr_in = 1'h0, reg_rd_in = 1'h0;
    logic secam_det_in = 1'h1, fsc_det_in = 1'h1, test_gain_in = 1'h0;
    logic vsync_in = 1'h0, odd_field_in = 1'h0, vact_in = 1'h0;
    logic comb_en_in = 1'h1, vact_out, comb_gate_out;
    logic [7:0] reg_idx_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
    logic [2:0] auto_luma_in = 3'h5, auto_chroma_in = 3'h6;
    proc_ctrl_pkg::proc_ctrl_t ctrl_out;
    int n_fail = 0, n_tests = 0;
    // {scaler, comb} path for vertical filter codes 0..4
    logic [3:0] vtbl [5] = '{4'h7, 4'h8, 4'h2, 4'h4, 4'h3};
    always #12.5 mclk_in = ~mclk_in;
    video_decoder_proc_controls dut (.mclk_in, .rst_n_in, .reg_wr_in,
        .reg_rd_in, .reg_idx_in, .reg_wdata_in, .reg_rdata_out,
        .secam_det_in, .fsc_det_in, .test_gain_in, .auto_luma_in,
        .auto_chroma_in, .vsync_in, .odd_field_in, .vact_in, .comb_en_in,
        .ctrl_out, .vact_out, .comb_gate_out);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
        @(posedge mclk_in);
        {reg_wr_in, reg_idx_in, reg_wdata_in} <= {1'h1, idx, dat};
        @(posedge mclk_in);
        reg_wr_in <= 1'h0;
        tick(2);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        @(posedge mclk_in);
        {reg_rd_in, reg_idx_in} <= {1'h1, idx};
        @(posedge mclk_in);
        reg_rd_in <= 1'h0;
        #1;
        chk({8'h00, reg_rdata_out}, {8'h00, exp});
    endtask : rd
    task automatic t_subcarrier_decode_ctrl_status;
        logic [1:0] k;
        rd(proc_ctrl_pkg::IDX_VERT_C, proc_ctrl_pkg::RST_VERT_C);
        rd(proc_ctrl_pkg::IDX_SUBCARRIER_DECODE_CTRL_STATUS, 8'hc0);
        @(posedge mclk_in);
        secam_det_in <= 1'h0;
        for (int c = 0; c < 4; c++) begin
            k = c[1:0];
            wr(proc_ctrl_pkg::IDX_SUBCARRIER_DECODE_CTRL_STATUS, {4'hf, k, k});
            rd(proc_ctrl_pkg::IDX_SUBCARRIER_DECODE_CTRL_STATUS, {4'hb, k, k});
            chk({ctrl_out.subcarrier_decode_ctrl_status_lpf_bypass, ctrl_out.track_field_only,
                ctrl_out.secam_assumed, ctrl_out.fsc_358},
                {2'h3, k == 2'h3, k != 2'h2});
        end
        wr(proc_ctrl_pkg::IDX_COLOR_GAIN, 8'h80);
        wr(proc_ctrl_pkg::IDX_TINT, 8'h81);
        chk({ctrl_out.color_gain, ctrl_out.tint}, 16'h8081);
        chk({15'h0, ctrl_out.gain_signed}, 16'h1);
        chk({15'h0, comb_gate_out}, 16'h1);
        @(posedge mclk_in);
        test_gain_in <= 1'h1;
        tick(2);
        chk({15'h0, ctrl_out.gain_signed}, 16'h0);
        wr(proc_ctrl_pkg::IDX_CHROMA_LAG, 8'h9c);
        rd(proc_ctrl_pkg::IDX_CHROMA_LAG, 8'h9c);
        chk({12'h0, ctrl_out.chroma_lag}, 16'h9);
        $display("subcarrier_decode_ctrl_status and colour test done");
    endtask : t_subcarrier_decode_ctrl_status
    task automatic t_vert;
        chk({ctrl_out.luma_coef, ctrl_out.chroma_coef}, 16'h2e);
        for (int c = 0; c < 5; c++) begin
            wr(proc_ctrl_pkg::IDX_VERT_A, {5'h1f, c[2:0]});
            chk({ctrl_out.scaler_path, ctrl_out.comb_path, ctrl_out.five_tap,
                ctrl_out.luma_coef, ctrl_out.luma_coef_auto},
                {vtbl[c], 5'h1e});
        end
        wr(proc_ctrl_pkg::IDX_VERT_B, 8'h8d);
        rd(proc_ctrl_pkg::IDX_VERT_B, 8'h8c);
        chk({ctrl_out.hlpf_bw, ctrl_out.decim_on, ctrl_out.decim_wide,
            ctrl_out.vscale_on, ctrl_out.line_delay},
            16'h81);
        wr(proc_ctrl_pkg::IDX_VERT_C, 8'hf6);
        chk({ctrl_out.chroma_mute, ctrl_out.chroma_coef,
            ctrl_out.luma_vert_reduced}, 16'h1f);
        @(posedge mclk_in);
        {vact_in, odd_field_in} <= 2'h3;
        tick(2);
        chk({15'h0, vact_out}, 16'h0);
        @(posedge mclk_in);
        odd_field_in <= 1'h0;
        tick(2);
        chk({15'h0, vact_out}, 16'h1);
        wr(proc_ctrl_pkg::IDX_VERT_C, 8'h0b);
        chk({ctrl_out.acomb_on, ctrl_out.chroma_coef}, 16'he);
        $display("vertical processing test done");
    endtask : t_vert
    task automatic t_ratio;
        wr(proc_ctrl_pkg::IDX_HRATIO_HIGH, 8'h5a);
        wr(proc_ctrl_pkg::IDX_HRATIO_LOW, 8'h35);
        wr(proc_ctrl_pkg::IDX_VRATIO_HIGH, 8'ha5);
        wr(proc_ctrl_pkg::IDX_VRATIO_LOW, 8'h4e);
        chk({1'h0, ctrl_out.horiz_ratio}, 16'h0);
        chk({2'h0, ctrl_out.vert_ratio}, 16'h0);
        @(posedge mclk_in);
        vsync_in <= 1'h1;
        tick(3);
        @(posedge mclk_in);
        vsync_in <= 1'h0;
        comb_en_in <= 1'h0;
        tick(3);
        chk({1'h0, ctrl_out.horiz_ratio}, 16'h2d1a);
        chk({2'h0, ctrl_out.vert_ratio}, 16'h2953);
        chk({14'h0, ctrl_out.acomb_coef75, ctrl_out.acomb_thr_low},
            16'h2);
        chk({15'h0, comb_gate_out}, 16'h1);
        $display("ratio test done");
    endtask : t_ratio
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (10) @(posedge mclk_in);
        rst_n_in <= 1'h1;
        t_subcarrier_decode_ctrl_status();
        t_vert();
        t_ratio();
        report_and_stop();
    end
    initial begin
        repeat (100000) @(posedge mclk_in);
        n_fail++;
        report_and_stop();
    end
endmodule : video_decoder_proc_controls_test
`default_nettype wire
